// ===== hw/external_memory_port_pkg.sv
package external_memory_port_pkg;

   // Sector boundary granularity and largest upper-sector start
   localparam logic [15:0] SECTOR_STEP = 16'h2000;
   localparam logic [15:0] SECTOR_TOP = 16'hE000;
   localparam logic [2:0] SECTOR_ONE_CODE = 3'h0;

   // Wait-state encodings of a sector wait field pair
   localparam logic [1:0] WAIT_NONE = 2'h0;
   localparam logic [1:0] WAIT_ONE = 2'h1;
   localparam logic [1:0] WAIT_TWO = 2'h2;
   localparam logic [1:0] WAIT_TWO_RECOV = 2'h3;

   // High address mask: code 7 releases every high pin
   localparam logic [2:0] MASK_NONE_CODE = 3'h7;
   localparam logic [7:0] HIGH_ALL = 8'hFF;

   // Default last address of internal SRAM; the external space starts above it
   localparam logic [15:0] INT_SRAM_END_DEF = 16'h10FF;

   // Bus state codes, Gray along address, latch, strobe, recovery, trailing latch
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_LATCH = 3'h3,
      ST_STROBE = 3'h2,
      ST_RECOV = 3'h6,
      ST_TRAIL = 3'h7
   } bus_state_t;

   // Extra strobe cycles beyond the first for a wait code
   function automatic logic [1:0] strobe_extra(input logic [1:0] code);
      logic [1:0] r;
      r = (code == WAIT_NONE) ? 2'h0 : ((code == WAIT_ONE) ? 2'h1 : 2'h2);
      return r;
   endfunction

endpackage

// ===== hw/external_memory_interface.sv
`timescale 1ns/100ps
module external_memory_interface #(
   parameter logic [15:0] INT_SRAM_END = external_memory_port_pkg::INT_SRAM_END_DEF
) (
   input wire logic core_clk_in, // System clock, 20 MHz
   input wire logic reset_in, // Synchronous reset, active high
   input wire logic ext_port_enable_in, // Port enable control bit
   input wire logic [2:0] sector_limit_code_in, // Sector split code
   input wire logic upper_wait_hi_in, // Upper sector wait, high bit
   input wire logic upper_wait_lo_in, // Upper sector wait, low bit
   input wire logic lower_wait_hi_in, // Lower sector wait, high bit
   input wire logic lower_wait_lo_in, // Lower sector wait, low bit
   input wire logic bus_keeper_enable_in, // Bus keeper on muxed lines
   input wire logic [2:0] high_addr_mask_code_in, // High address width code
   input wire logic req_in, // Access request pulse
   input wire logic req_write_in, // Request is a write
   input wire logic [15:0] req_addr_in, // Data-space address
   input wire logic [7:0] req_wdata_in, // Write data
   input wire logic next_ram_in, // Next instruction accesses RAM
   output logic busy_out, // Cycle in progress
   output logic done_out, // Access finished, one-cycle pulse
   output logic [7:0] rdata_out, // Read data
   output logic ext_hit_out, // Last access was external
   input wire logic [7:0] low_port_data_in, // Port output bits of muxed pins
   input wire logic [7:0] low_port_dir_in, // Port direction bits of muxed pins
   input wire logic [7:0] high_port_data_in, // Port output bits of high pins
   input wire logic [7:0] high_port_dir_in, // Port direction bits of high pins
   input wire logic [7:0] muxed_addr_data_bus_in, // Muxed bus pin level
   output logic [7:0] muxed_addr_data_bus_out, // Muxed bus drive value
   output logic [7:0] muxed_addr_data_bus_oe_out, // Muxed bus drive enable
   output logic [7:0] muxed_pullup_out, // Pull-up enable per muxed pin
   output logic [7:0] muxed_keeper_en_out, // Keeper active per muxed pin
   output logic [7:0] muxed_keeper_level_out, // Level the keeper holds
   output logic [7:0] high_address_bus_out, // High address drive value
   output logic [7:0] high_address_bus_oe_out, // High address drive enable
   output logic ale_out, // Address latch strobe, active high
   output logic rd_n_out, // Read strobe, active low
   output logic wr_n_out // Write strobe, active low
);

   external_memory_port_pkg::bus_state_t state_r;
   logic [15:0] addr_r;
   logic [7:0] wdata_r;
   logic we_r, ext_r, next_r, recov_r;
   logic [1:0] cnt_r;
   logic done_r;
   logic [7:0] rdata_r;
   logic [7:0] sync1_r, sync2_r, sync3_r, flt_r;
   logic [7:0] keep_r;
   logic [1:0] upper_wait, lower_wait, wait_sel;
   logic [1:0] wait_sel_r;
   logic rd_cap1_r, rd_cap2_r;
   logic req_ext, upper_hit, take;
   logic m_oe, m_ale, m_rd, m_wr;
   logic [7:0] m_val, hi_mask;

   // Wait pairs and sector choice for the incoming address
   assign upper_wait = {upper_wait_hi_in, upper_wait_lo_in};
   assign lower_wait = {lower_wait_hi_in, lower_wait_lo_in};
   assign req_ext = req_addr_in > INT_SRAM_END;
   assign upper_hit = (sector_limit_code_in == external_memory_port_pkg::SECTOR_ONE_CODE)
      || (req_addr_in >= 16'(16'(sector_limit_code_in) * external_memory_port_pkg::SECTOR_STEP));
   assign wait_sel = !req_ext ? external_memory_port_pkg::WAIT_NONE
      : (upper_hit ? upper_wait : lower_wait);
   assign take = req_in && (state_r == external_memory_port_pkg::ST_IDLE);

   // Bus cycle sequencer
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         state_r <= external_memory_port_pkg::ST_IDLE;
         cnt_r <= 2'h0;
      end else begin
         unique case (state_r)
            external_memory_port_pkg::ST_IDLE: begin
               // Disabled port never runs a pin cycle
               if (take && ext_port_enable_in) begin
                  state_r <= external_memory_port_pkg::ST_ADDR;
               end
            end
            external_memory_port_pkg::ST_ADDR: begin
               state_r <= external_memory_port_pkg::ST_LATCH;
            end
            external_memory_port_pkg::ST_LATCH: begin
               state_r <= external_memory_port_pkg::ST_STROBE;
               cnt_r <= external_memory_port_pkg::strobe_extra(wait_sel_r);
            end
            external_memory_port_pkg::ST_STROBE: begin
               if (cnt_r != 2'h0) begin
                  cnt_r <= cnt_r - 2'h1;
               end else if (recov_r) begin
                  state_r <= external_memory_port_pkg::ST_RECOV;
               end else if (next_r) begin
                  state_r <= external_memory_port_pkg::ST_TRAIL;
               end else begin
                  state_r <= external_memory_port_pkg::ST_IDLE;
               end
            end
            external_memory_port_pkg::ST_RECOV: begin
               state_r <= next_r ? external_memory_port_pkg::ST_TRAIL : external_memory_port_pkg::ST_IDLE;
            end
            external_memory_port_pkg::ST_TRAIL: begin
               state_r <= external_memory_port_pkg::ST_IDLE;
            end
            default: begin
               state_r <= external_memory_port_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Request capture; the wait choice is frozen so a config change mid-cycle is harmless
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         addr_r <= 16'h0000;
         wdata_r <= 8'h00;
         we_r <= 1'b0;
         ext_r <= 1'b0;
         next_r <= 1'b0;
         recov_r <= 1'b0;
         wait_sel_r <= 2'h0;
      end else if (take) begin
         addr_r <= req_addr_in;
         wdata_r <= req_wdata_in;
         we_r <= req_write_in;
         ext_r <= req_ext && ext_port_enable_in;
         next_r <= next_ram_in;
         recov_r <= wait_sel == external_memory_port_pkg::WAIT_TWO_RECOV;
         wait_sel_r <= wait_sel;
      end
   end

   // Completion pulse and read data
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         done_r <= 1'b0;
         rdata_r <= 8'h00;
         rd_cap1_r <= 1'b0;
         rd_cap2_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         // Pin data is two edges behind the strobe end through the sync chain
         rd_cap1_r <= 1'b0;
         rd_cap2_r <= rd_cap1_r;
         if (rd_cap2_r) begin
            rdata_r <= flt_r;
         end
         if (take && !ext_port_enable_in) begin
            done_r <= 1'b1;
            rdata_r <= 8'h00;
         end else if (state_r == external_memory_port_pkg::ST_STROBE && cnt_r == 2'h0) begin
            done_r <= 1'b1;
            // Internal data comes from the SRAM itself, not from the pins
            rdata_r <= (ext_r && !we_r) ? flt_r : 8'h00;
            rd_cap1_r <= ext_r && !we_r;
         end
      end
   end

   // Pin input sync; the filtered value moves only when stages two and three agree
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         sync1_r <= 8'h00;
         sync2_r <= 8'h00;
         sync3_r <= 8'h00;
         flt_r <= 8'h00;
      end else begin
         sync1_r <= muxed_addr_data_bus_in;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         if (sync2_r == sync3_r) begin
            flt_r <= sync3_r;
         end
      end
   end

   // Keeper remembers the driven value, or the pin level while released
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         keep_r <= 8'h00;
      end else begin
         keep_r <= (muxed_addr_data_bus_oe_out & muxed_addr_data_bus_out)
            | (~muxed_addr_data_bus_oe_out & flt_r);
      end
   end

   // Pin activity decoded from the sequencer state
   always_comb begin
      m_oe = (state_r == external_memory_port_pkg::ST_ADDR) || (state_r == external_memory_port_pkg::ST_LATCH)
         || (state_r == external_memory_port_pkg::ST_STROBE && we_r);
      m_val = (state_r == external_memory_port_pkg::ST_STROBE) ? wdata_r : addr_r[7:0];
      m_ale = (state_r == external_memory_port_pkg::ST_ADDR) || (state_r == external_memory_port_pkg::ST_TRAIL);
      m_rd = (state_r == external_memory_port_pkg::ST_STROBE) && ext_r && !we_r;
      m_wr = (state_r == external_memory_port_pkg::ST_STROBE) && ext_r && we_r;
   end

   // Driven high bits: code 7 releases all, otherwise the top code bits go back
   assign hi_mask = (high_addr_mask_code_in == external_memory_port_pkg::MASK_NONE_CODE) ? 8'h00
      : (external_memory_port_pkg::HIGH_ALL >> high_addr_mask_code_in);

   // Per-pin override of port direction and data while enabled
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_pin
         assign muxed_addr_data_bus_oe_out[i] = ext_port_enable_in ? m_oe
            : low_port_dir_in[i];
         assign muxed_addr_data_bus_out[i] = ext_port_enable_in ? m_val[i]
            : low_port_data_in[i];
         assign high_address_bus_oe_out[i] = (ext_port_enable_in && hi_mask[i])
            || high_port_dir_in[i] && !(ext_port_enable_in && hi_mask[i]);
         assign high_address_bus_out[i] = (ext_port_enable_in && hi_mask[i])
            ? addr_r[8 + i] : high_port_data_in[i];
         assign muxed_pullup_out[i] = low_port_data_in[i]
            && !muxed_addr_data_bus_oe_out[i];
         assign muxed_keeper_en_out[i] = bus_keeper_enable_in
            && !muxed_addr_data_bus_oe_out[i];
      end
   endgenerate

   // Strobes stay idle while the port is off; all edges follow core_clk_in only
   assign ale_out = ext_port_enable_in && m_ale;
   assign rd_n_out = !(ext_port_enable_in && m_rd);
   assign wr_n_out = !(ext_port_enable_in && m_wr);
   assign muxed_keeper_level_out = keep_r;
   assign busy_out = state_r != external_memory_port_pkg::ST_IDLE;
   assign done_out = done_r;
   assign rdata_out = rdata_r;
   assign ext_hit_out = ext_r;

   // Strobe length helper for checking
   logic [2:0] low_len_r;
   logic [2:0] exp_len;
   assign exp_len = 3'(external_memory_port_pkg::strobe_extra(wait_sel_r)) + 3'h1;
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         low_len_r <= 3'h0;
      end else begin
         low_len_r <= (!rd_n_out || !wr_n_out) ? 3'(low_len_r + 3'h1) : 3'h0;
      end
   end

   chk_ale_fall_addr: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      $fell(ale_out) && state_r == external_memory_port_pkg::ST_LATCH
      |-> muxed_addr_data_bus_out == addr_r[7:0] && &muxed_addr_data_bus_oe_out)
      else $error("low address not valid at latch fall");

   chk_ale_low_data: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      state_r == external_memory_port_pkg::ST_LATCH |=> !ale_out throughout (state_r == external_memory_port_pkg::ST_STROBE))
      else $error("latch strobe high during data phase");

   chk_internal_quiet: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      take && ext_port_enable_in && !req_ext |=> (rd_n_out && wr_n_out) [*3])
      else $error("strobe toggled on internal access");

   chk_disabled_pins: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      !ext_port_enable_in |-> muxed_addr_data_bus_oe_out == low_port_dir_in
         && !ale_out && rd_n_out)
      else $error("pins not returned to port");

   chk_no_alias: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      take && !ext_port_enable_in && req_ext |=> done_out && rdata_out == 8'h00 && !busy_out)
      else $error("external address aliased while disabled");

   chk_strobe_len: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      ($rose(rd_n_out) || $rose(wr_n_out)) |-> low_len_r == exp_len)
      else $error("strobe length does not match wait code");

   chk_recov_gap: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      state_r == external_memory_port_pkg::ST_RECOV
      |-> rd_n_out && wr_n_out && muxed_addr_data_bus_oe_out == 8'h00 && !ale_out)
      else $error("new address driven during recovery");

   chk_trail_pulse: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      ($rose(rd_n_out) || $rose(wr_n_out)) && !recov_r |-> ale_out == next_r)
      else $error("trailing latch pulse misplaced");

   chk_sector_pick: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      take && req_ext && sector_limit_code_in == 3'h0
      |=> wait_sel_r == $past(upper_wait))
      else $error("single sector not timed by upper pair");

endmodule

// ===== testbench/ext_sram_model.sv
`timescale 1ns/100ps
// Far-side memory behind an octal address latch; it has no clock of its own
module ext_sram_model #(
   parameter int RD_DLY = 5 // Access time in ns
) (
   input wire logic ale_in, // Latch gate
   input wire logic rd_n_in, // Read strobe, active low
   input wire logic wr_n_in, // Write strobe, active low
   input wire logic [7:0] bus_in, // Muxed bus level
   output logic [7:0] bus_out, // Read data drive value
   output logic [7:0] bus_oe_out // Read data drive enable
);
   logic [7:0] lat_r;
   logic [7:0] mem [0:255];

   // Transparent while the gate is high, holds once it falls
   always_latch begin
      if (ale_in) lat_r <= bus_in;
   end

   // Data taken well inside the strobe, since pin edges are not clock-aligned
   always @(negedge wr_n_in) begin
      #20 mem[lat_r] = bus_in;
   end

   // Drive only while the read strobe is low, after the access time
   assign #(RD_DLY) bus_out = mem[lat_r];
   assign #(RD_DLY) bus_oe_out = {8{~rd_n_in}};
endmodule

// ===== testbench/tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
$display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
module tb;
   logic core_clk_in = 1'b0, reset_in = 1'b1, ext_port_enable_in = 1'b0;
   logic upper_wait_hi_in = 1'b0, upper_wait_lo_in = 1'b0;
   logic lower_wait_hi_in = 1'b0, lower_wait_lo_in = 1'b0;
   logic bus_keeper_enable_in = 1'b0, req_in = 1'b0, req_write_in = 1'b0, next_ram_in = 1'b0;
   logic [2:0] sector_limit_code_in = 3'h0, high_addr_mask_code_in = 3'h0;
   logic [15:0] req_addr_in = 16'h0000;
   logic [7:0] req_wdata_in = 8'h00, low_port_data_in = 8'h00, low_port_dir_in = 8'h00;
   logic [7:0] high_port_data_in = 8'h00, high_port_dir_in = 8'h00;
   logic busy_out, done_out, ext_hit_out, ale_out, rd_n_out, wr_n_out;
   logic [7:0] rdata_out, muxed_addr_data_bus_out, muxed_addr_data_bus_oe_out, muxed_pullup_out;
   logic [7:0] muxed_keeper_en_out, muxed_keeper_level_out, high_address_bus_out;
   logic [7:0] high_address_bus_oe_out, p_d, p_oe, fl, bus_w, last_w = 8'h00, hm = 8'hFF;
   int err_count = 0, n_checks = 0;

   // Pin level: device, then memory, then keeper, pull-up or a drifting float
   assign fl = (muxed_keeper_en_out & muxed_keeper_level_out) |
      (~muxed_keeper_en_out & (muxed_pullup_out | ~last_w));
   assign bus_w = (muxed_addr_data_bus_oe_out & muxed_addr_data_bus_out) |
      (~muxed_addr_data_bus_oe_out & ((p_oe & p_d) | (~p_oe & fl)));
   always @(posedge core_clk_in) last_w <= bus_w;

   external_memory_interface external_memory_interface_i (.core_clk_in, .reset_in,
      .ext_port_enable_in, .sector_limit_code_in, .upper_wait_hi_in, .upper_wait_lo_in,
      .lower_wait_hi_in, .lower_wait_lo_in, .bus_keeper_enable_in, .high_addr_mask_code_in,
      .req_in, .req_write_in, .req_addr_in, .req_wdata_in, .next_ram_in, .busy_out, .done_out,
      .rdata_out, .ext_hit_out, .low_port_data_in, .low_port_dir_in, .high_port_data_in,
      .high_port_dir_in, .muxed_addr_data_bus_in(bus_w), .muxed_addr_data_bus_out,
      .muxed_addr_data_bus_oe_out, .muxed_pullup_out, .muxed_keeper_en_out,
      .muxed_keeper_level_out, .high_address_bus_out, .high_address_bus_oe_out, .ale_out,
      .rd_n_out, .wr_n_out);

   ext_sram_model ext_sram_model_i (.ale_in(ale_out), .rd_n_in(rd_n_out), .wr_n_in(wr_n_out),
      .bus_in(bus_w), .bus_out(p_d), .bus_oe_out(p_oe));

   task automatic tick();
      @(posedge core_clk_in);
      #1;
   endtask

   task automatic waits(input logic [1:0] u, input logic [1:0] l);
      {upper_wait_hi_in, upper_wait_lo_in} = u;
      {lower_wait_hi_in, lower_wait_lo_in} = l;
   endtask

   // One access: ns strobe cycles, done at cycle lat, nale latch pulses
   task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
         input logic nr, input int ns, input int lat, input int nale);
      int st, ot, al, dn;
      logic aq;
      st = 0;
      ot = 0;
      al = 0;
      dn = 0;
      aq = 1'b0;
      req_write_in = wr;
      req_addr_in = a;
      req_wdata_in = d;
      next_ram_in = nr;
      req_in = 1'b1;
      tick();
      req_in = 1'b0;
      // Sample mid-cycle so every output has settled
      for (int n = 1; n < 12; n++) begin
         @(negedge core_clk_in);
         if (n < 3 && nale > 0) `CHK({ale_out, bus_w}, {1'(n == 1), a[7:0]})
         if (n == 1 && nale > 0) `CHK({high_address_bus_oe_out, high_address_bus_out & hm},
            {hm, a[15:8] & hm})
         `CHK(ale_out & ~(rd_n_out & wr_n_out), 1'b0)
         if (n == lat) `CHK(done_out, 1'b1)
         st += wr ? !wr_n_out : !rd_n_out;
         ot += wr ? !rd_n_out : !wr_n_out;
         al += ale_out & !aq;
         dn += done_out;
         aq = ale_out;
      end
      `CHK({st, ot, al, dn}, {ns, 32'd0, nale, 32'd1})
      tick();
   endtask

   task automatic t_disabled();
      bus_keeper_enable_in = 1'b1;
      low_port_dir_in = 8'h0F;
      low_port_data_in = 8'h3C;
      high_port_dir_in = 8'h55;
      tick();
      `CHK({muxed_addr_data_bus_oe_out, muxed_addr_data_bus_out & 8'h0F}, 16'h0F0C)
      `CHK({muxed_pullup_out, muxed_keeper_en_out}, 16'h30F0)
      `CHK(high_address_bus_oe_out, 8'h55)
      acc(1'b0, 16'h8000, 8'h00, 1'b1, 0, 1, 0);
      `CHK({ext_hit_out, rdata_out}, 9'h000)
      low_port_dir_in = 8'h00;
      low_port_data_in = 8'h00;
      high_port_dir_in = 8'h00;
      ext_port_enable_in = 1'b1;
      tick();
      `CHK({muxed_addr_data_bus_oe_out, muxed_keeper_en_out}, 16'h00FF)
      $display("test disabled done");
   endtask

   // Lower pair set opposite, so a wrong pair changes the strobe length
   task automatic t_wait();
      int e;
      for (int c = 0; c < 4; c++) begin
         e = c > 1 ? 2 : c;
         waits(2'(c), ~2'(c));
         acc(1'b1, 16'h8010 + 16'(c), 8'hA5 ^ 8'(c), 1'b1, 1 + e, 4 + e, 2);
         acc(1'b0, 16'h8010 + 16'(c), 8'h00, 1'b0, 1 + e, 4 + e, 1);
         `CHK(ext_hit_out, 1'b1)
         if (c > 1) `CHK(rdata_out, 8'hA5 ^ 8'(c))
      end
      $display("test wait done");
   endtask

   task automatic t_sector();
      int k;
      logic [15:0] b;
      waits(2'h3, 2'h0);
      for (int i = 0; i < 3; i++) begin
         k = i == 0 ? 1 : (i == 1 ? 2 : 7);
         sector_limit_code_in = 3'(k);
         b = 16'(k) * 16'h2000;
         acc(1'b1, b - 16'h0001, 8'h11, 1'b0, 1, 4, 1);
         acc(1'b1, b, 8'h22, 1'b0, 3, 6, 1);
      end
      sector_limit_code_in = 3'h0;
      $display("test sector done");
   endtask

   // Internal space keeps latch activity but never strobes
   task automatic t_internal();
      acc(1'b0, 16'h0800, 8'h00, 1'b1, 0, 4, 2);
      `CHK({ext_hit_out, rdata_out}, 9'h000)
      acc(1'b1, 16'h0801, 8'h77, 1'b0, 0, 4, 1);
      $display("test internal done");
   endtask

   task automatic t_mask();
      waits(2'h0, 2'h0);
      for (int k = 0; k < 8; k++) begin
         high_addr_mask_code_in = 3'(k);
         // Code 7 drives no high bit at all
         hm = (k == 7) ? 8'h00 : (8'hFF >> k);
         acc(1'b1, 16'hFF40, 8'h5A, 1'b0, 1, 4, 1);
      end
      high_addr_mask_code_in = 3'h0;
      hm = 8'hFF;
      $display("test mask done");
   endtask

   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      forever #25 core_clk_in = ~core_clk_in;
   end

   // Watchdog, roughly thirteen times the expected run
   initial begin
      #200000;
      err_count++;
      conclude();
   end

   initial begin
      repeat (10) @(posedge core_clk_in);
      #1 reset_in = 1'b0;
      `CHK({busy_out, done_out, ale_out, rd_n_out, wr_n_out, rdata_out}, 13'h0300)
      $display("test reset done");
      t_disabled();
      t_wait();
      t_sector();
      t_internal();
      t_mask();
      conclude();
   end
endmodule
